// file: design/epb_bridge.sv
// Purpose: capture/compare/pwm unit with single, half and full bridge out
// Assumes: pclk is the oscillator, all inputs synchronous to pclk
// Notes:   registers on apb; one level interrupt from status and mask
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module epb_bridge (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  capture_in,
    output epb_pkg::epb_pins_type      bridge_pins,
    output logic                       irq
);
    epb_pkg::epb_state_type s;
    epb_pkg::epb_state_type n;

    logic       acc;
    logic       wr;
    logic       rd;
    logic [3:0] mode;
    logic       pwm;
    logic       fb;
    logic       tick;
    logic [3:0] tc;
    logic       per_end;
    logic       win;
    logic       pmod;
    logic       dir_eff;
    logic       match;
    logic       cap_ev;
    logic [1:0] ev;
    logic [1:0] clr;
    logic [3:0] act;
    logic       dead_on;

    always_comb begin
        n = s;
        acc = psel & penable & s.pready;
        wr = acc & pwrite;
        rd = acc & ~pwrite;
        mode = s.ctrl[3:0];
        pwm = (mode[3:2] == 2'b11);
        fb = s.ctrl[epb_pkg::CFG_LO];
        ev = 2'b00;
        clr = 2'b00;
        act = 4'h0;
        match = 1'b0;
        cap_ev = 1'b0;
        // zero wait state: ready is registered in the setup cycle, high in the access cycle
        n.pready = psel & ~penable;
        if (psel && !penable) begin
            n.pslverr = 1'b0;
            unique case (paddr)
                epb_pkg::OFF_CTRL:   n.prdata = {24'h0, s.ctrl};
                epb_pkg::OFF_DUTY:   n.prdata = {24'h0, s.duty_hi};
                epb_pkg::OFF_PERIOD: n.prdata = {24'h0, s.period};
                epb_pkg::OFF_PRESC:  n.prdata = {30'h0, s.presc};
                epb_pkg::OFF_CMP:    n.prdata = {16'h0, s.cmp};
                epb_pkg::OFF_FIRST_TIMER_COUNT:   n.prdata = {16'h0, s.first_timer_count};
                epb_pkg::OFF_STAT:   n.prdata = {30'h0, s.stat};
                epb_pkg::OFF_MASK:   n.prdata = {30'h0, s.mask};
                default: begin
                    n.prdata = 32'h0;
                    n.pslverr = 1'b1;
                end
            endcase
        end
        if (rd && paddr == epb_pkg::OFF_STAT) begin
            clr = s.stat;
        end

        // prescaler for the period timer, divide 1, 4 or 16
        unique case (s.presc)
            2'b00:   tc = epb_pkg::PSC_TC1;
            2'b01:   tc = epb_pkg::PSC_TC4;
            default: tc = epb_pkg::PSC_TC16;
        endcase
        tick = pwm & (s.psc_cnt >= tc);
        per_end = tick && (s.fine == epb_pkg::FINE_TC)
                  && (s.tmr2 == s.period);
        if (pwm) begin
            n.psc_cnt = tick ? 4'h0 : 4'(s.psc_cnt + 4'h1);
        end
        if (tick) begin
            n.fine = 2'(s.fine + 2'h1);
            if (s.fine == epb_pkg::FINE_TC) begin
                n.tmr2 = (s.tmr2 == s.period) ? 8'h00
                                              : 8'(s.tmr2 + 8'h01);
            end
        end
        if (per_end) begin
            n.duty_lat = {s.duty_hi, s.ctrl[epb_pkg::DUTYL_HI:
                                            epb_pkg::DUTYL_LO]};
            n.dir = s.ctrl[epb_pkg::CFG_HI];
            ev[epb_pkg::ST_PERIOD] = 1'b1;
        end
        pmod = ({s.tmr2, s.fine} < s.duty_lat);

        // last timer count of the period is 4 tosc times the prescale
        win = pwm && fb && (s.tmr2 == s.period)
              && (s.dir != s.ctrl[epb_pkg::CFG_HI]);
        dir_eff = win ? s.ctrl[epb_pkg::CFG_HI] : s.dir;

        // dead band only guards the half-bridge pair
        n.pwm_prev = pmod;
        dead_on = (pmod != s.pwm_prev) || (s.dead != 4'h0);
        // the edge cycle itself is the first dead cycle of the gap
        if (pmod != s.pwm_prev) begin
            n.dead = 4'(epb_pkg::DEAD_CYC - 4'h1);
        end else if (s.dead != 4'h0) begin
            n.dead = 4'(s.dead - 4'h1);
        end

        // compare and capture time base
        if (!pwm && mode != epb_pkg::MODE_OFF) begin
            n.first_timer_count = 16'(s.first_timer_count + 16'h0001);
            match = (s.first_timer_count == s.cmp) && (mode[3] || mode == 4'b0010);
        end
        n.cap_prev = capture_in;
        if (mode[3:2] == 2'b01) begin
            if (mode == epb_pkg::MODE_CAP_F) begin
                cap_ev = s.cap_prev & ~capture_in;
            end else if (!s.cap_prev && capture_in) begin
                n.cap_cnt = 4'(s.cap_cnt + 4'h1);
                unique case (mode[1:0])
                    2'b01:   cap_ev = 1'b1;
                    2'b10:   cap_ev = (s.cap_cnt[1:0] == 2'b11);
                    default: cap_ev = (s.cap_cnt == 4'hf);
                endcase
            end
        end

        // register writes; hardware updates below take precedence
        if (wr) begin
            unique case (paddr)
                epb_pkg::OFF_CTRL: begin
                    n.ctrl = pwdata[7:0];
                    n.cmp_out = pwdata[0];
                end
                epb_pkg::OFF_DUTY:   n.duty_hi = pwdata[7:0];
                epb_pkg::OFF_PERIOD: n.period = pwdata[7:0];
                epb_pkg::OFF_PRESC:  n.presc = pwdata[1:0];
                epb_pkg::OFF_CMP:    n.cmp = pwdata[15:0];
                epb_pkg::OFF_MASK:   n.mask = pwdata[1:0];
                default: ;
            endcase
        end
        if (cap_ev) begin
            n.cmp = s.first_timer_count;
            ev[epb_pkg::ST_MATCH] = 1'b1;
        end
        if (match) begin
            ev[epb_pkg::ST_MATCH] = 1'b1;
            unique case (mode)
                epb_pkg::MODE_CMP_SET: n.cmp_out = 1'b1;
                epb_pkg::MODE_CMP_CLR: n.cmp_out = 1'b0;
                epb_pkg::MODE_CMP_TOG: n.cmp_out = ~s.cmp_out;
                epb_pkg::MODE_CMP_SPE: n.first_timer_count = 16'h0000;
                default: ;
            endcase
        end

        // pins
        n.pins.oe = 4'h0;
        n.pins.lvl = 4'h0;
        if (pwm) begin
            unique case (epb_pkg::epb_cfg_type'(s.ctrl[7:6]))
                epb_pkg::CFG_SINGLE: begin
                    n.pins.oe = 4'b0001;
                    act[0] = pmod;
                end
                epb_pkg::CFG_HALF: begin
                    n.pins.oe = 4'b0011;
                    act[0] = pmod & ~dead_on;
                    act[1] = ~pmod & ~dead_on;
                end
                default: begin
                    // no dead band in full bridge, one leg switches at once
                    n.pins.oe = 4'b1111;
                    if (!dir_eff) begin
                        act = {pmod & ~win, 1'b0, 1'b0, 1'b1};
                    end else begin
                        act = {1'b0, 1'b1, pmod & ~win, 1'b0};
                    end
                end
            endcase
            // mode bit1 inverts a/c, bit0 inverts b/d
            n.pins.lvl = act
                         ^ {mode[0], mode[1], mode[0], mode[1]};
        end else begin
            // only pin a is used, b..d left to the port
            if (mode == epb_pkg::MODE_CMP_SET || mode == epb_pkg::MODE_CMP_CLR
                || mode == epb_pkg::MODE_CMP_TOG) begin
                n.pins.oe = 4'b0001;
                n.pins.lvl = {3'b000, n.cmp_out};
            end
        end

        if (mode == epb_pkg::MODE_OFF) begin
            n.first_timer_count = 16'h0000;
            n.tmr2 = 8'h00;
            n.fine = 2'h0;
            n.psc_cnt = 4'h0;
            n.cap_cnt = 4'h0;
            n.dead = 4'h0;
            n.dir = 1'b0;
            n.duty_lat = 10'h000;
            n.pins = '0;
        end

        n.stat = (s.stat & ~clr) | ev;
        n.irq = |(n.stat & n.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.ctrl <= epb_pkg::CTRL_RST;
            s.duty_hi <= epb_pkg::DUTY_RST;
            s.period <= epb_pkg::PERIOD_RST;
            s.presc <= epb_pkg::PRESC_RST;
            s.cmp <= epb_pkg::CMP_RST;
            s.mask <= epb_pkg::MASK_RST;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign bridge_pins = s.pins;
    assign irq = s.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_win_open;
        win && (mode == 4'b1100);
    endsequence

    sequence seq_fwd_steady;
        (mode == 4'b1100) && (s.ctrl[7:6] == 2'b01) && !s.dir && !win;
    endsequence

    a_capcmp_port_pins: assert property (
        (s.ctrl[3:2] != 2'b11) |=> (s.pins.oe[3:1] == 3'b000))
        else $error("port pins driven in capture/compare mode");
    a_single_out_only: assert property (
        (mode == 4'b1100 && s.ctrl[7:6] == 2'b00 && pmod)
        |=> (s.pins.oe == 4'b0001) && s.pins.lvl[0])
        else $error("single output mode drives wrong pins");
    a_fwd_drive_pins: assert property (
        seq_fwd_steady |=> s.pins.lvl[0] && !s.pins.lvl[1]
                           && !s.pins.lvl[2] && (s.pins.oe == 4'hf))
        else $error("forward bridge pins wrong");
    a_half_no_overlap: assert property (
        (mode == 4'b1100 && s.ctrl[7:6] == 2'b10)
        |=> (s.pins.oe == 4'b0011) && !(s.pins.lvl[0] && s.pins.lvl[1]))
        else $error("half bridge pair overlaps");
    a_rev_drive_pins: assert property (
        (mode == 4'b1100 && s.ctrl[7:6] == 2'b11 && s.dir && !win)
        |=> s.pins.lvl[2] && !s.pins.lvl[0] && !s.pins.lvl[3])
        else $error("reverse bridge pins wrong");
    a_duty_ten_bits: assert property (
        per_end |=> (s.duty_lat == {$past(s.duty_hi), $past(s.ctrl[5:4])}))
        else $error("duty latch not ten-bit duty");
    a_cmp_set_high: assert property (
        (mode == 4'b1000 && match && !wr) |=> s.pins.lvl[0] && s.stat[0])
        else $error("compare set did not drive high");
    a_cmp_clr_low: assert property (
        (mode == 4'b1001 && match && !wr) |=> !s.pins.lvl[0] && s.stat[0])
        else $error("compare clear did not drive low");
    a_swi_pin_free: assert property (
        (mode == 4'b1010 && match) |=> !s.pins.oe[0] && s.stat[0])
        else $error("software compare drove pin or missed flag");
    a_spe_timer_reset: assert property (
        (mode == 4'b1011 && match) |=> (s.first_timer_count == 16'h0000))
        else $error("special event did not clear timer");
    a_pol_inactive: assert property (
        (pwm && s.ctrl[7:6] == 2'b00 && !pmod)
        |=> (s.pins.lvl[0] == $past(s.ctrl[1])))
        else $error("inactive level ignores polarity");
    a_dir_next_period: assert property (
        per_end |=> (s.dir == $past(s.ctrl[7])))
        else $error("direction not taken at period end");
    a_window_mod_off: assert property (
        seq_win_open |=> !s.pins.lvl[1] && !s.pins.lvl[3])
        else $error("modulated pin active in reversal window");
    a_presc_four: assert property (
        (s.presc == 2'b01 && tick && pwm && !psel) |=> !tick [*3])
        else $error("prescale 4 ticks too often");
    a_fb_no_dead: assert property (
        (seq_fwd_steady and (pmod && s.dead != 4'h0)) |=> s.pins.lvl[3])
        else $error("full bridge delayed by dead band");
    a_off_resets: assert property (
        (mode == 4'b0000) |=> (s.pins.oe == 4'h0) && (s.first_timer_count == 16'h0000))
        else $error("mode off left state running");
    a_half_dead_gap: assert property (
        (mode == 4'b1100 && s.ctrl[7:6] == 2'b10 && pmod != s.pwm_prev)
        |=> (s.pins.lvl[1:0] == 2'b00))
        else $error("half bridge edge without dead band");
    a_stat_read_clr: assert property (
        (rd && paddr == epb_pkg::OFF_STAT && ev == 2'b00)
        |=> (s.stat == 2'b00))
        else $error("status read did not clear");
endmodule

// file: design/epb_pkg.sv
// Purpose: constants and types for the enhanced pwm bridge control block
// Assumes: apb slave, 32-bit data, one word per register
// Notes:   offsets, resets, fields, prescale, timing and mode codes are named here
package epb_pkg;
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_DUTY   = 8'h04;
    localparam logic [7:0] OFF_PERIOD = 8'h08;
    localparam logic [7:0] OFF_PRESC  = 8'h0c;
    localparam logic [7:0] OFF_CMP    = 8'h10;
    localparam logic [7:0] OFF_FIRST_TIMER_COUNT   = 8'h14;
    localparam logic [7:0] OFF_STAT   = 8'h18;
    localparam logic [7:0] OFF_MASK   = 8'h1c;

    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [7:0]  DUTY_RST   = 8'h00;
    localparam logic [7:0]  PERIOD_RST = 8'hff;
    localparam logic [1:0]  PRESC_RST  = 2'h0;
    localparam logic [15:0] CMP_RST    = 16'h0000;
    localparam logic [1:0]  MASK_RST   = 2'h0;

    // control register field positions
    localparam int CFG_HI   = 7;
    localparam int CFG_LO   = 6;
    localparam int DUTYL_HI = 5;
    localparam int DUTYL_LO = 4;

    // status / mask bit positions
    localparam int ST_MATCH  = 0;
    localparam int ST_PERIOD = 1;

    // prescaler terminal counts for divide by 1, 4 and 16
    localparam logic [3:0] PSC_TC1  = 4'h0;
    localparam logic [3:0] PSC_TC4  = 4'h3;
    localparam logic [3:0] PSC_TC16 = 4'hf;

    // timing: pclk is the oscillator, the fine count spans 4 tosc
    localparam int CLK_NS       = 8;
    localparam int TOSC_NS      = 8;
    localparam int DIR_WIN_TOSC = 4;
    localparam int FINE_LAST    = DIR_WIN_TOSC - 1;
    localparam int DEAD_NS      = 16;
    localparam int DEAD_CYC_I   = (DEAD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] DEAD_CYC = 4'(DEAD_CYC_I);
    localparam logic [1:0] FINE_TC  = 2'(FINE_LAST * TOSC_NS / CLK_NS);

    typedef enum logic [3:0] {
        MODE_OFF     = 4'b0000,
        MODE_CMP_TOG = 4'b0010,
        MODE_CAP_F   = 4'b0100,
        MODE_CAP_R   = 4'b0101,
        MODE_CAP_R4  = 4'b0110,
        MODE_CAP_R16 = 4'b0111,
        MODE_CMP_SET = 4'b1000,
        MODE_CMP_CLR = 4'b1001,
        MODE_CMP_SWI = 4'b1010,
        MODE_CMP_SPE = 4'b1011,
        MODE_PWM_HH  = 4'b1100
    } epb_mode_type;

    typedef enum logic [1:0] {
        CFG_SINGLE = 2'b00,
        CFG_FWD    = 2'b01,
        CFG_HALF   = 2'b10,
        CFG_REV    = 2'b11
    } epb_cfg_type;

    // index 0..3 are bridge_out_a..bridge_out_d
    typedef struct packed {
        logic [3:0] lvl;
        logic [3:0] oe;
    } epb_pins_type;

    typedef struct packed {
        logic [7:0]   ctrl;
        logic [7:0]   duty_hi;
        logic [7:0]   period;
        logic [1:0]   presc;
        logic [15:0]  cmp;
        logic [1:0]   mask;
        logic [1:0]   stat;
        logic [15:0]  first_timer_count;
        logic [7:0]   tmr2;
        logic [1:0]   fine;
        logic [3:0]   psc_cnt;
        logic [9:0]   duty_lat;
        logic         dir;
        logic [3:0]   cap_cnt;
        logic         cap_prev;
        logic         cmp_out;
        logic         pwm_prev;
        logic [3:0]   dead;
        epb_pins_type pins;
        logic         irq;
        logic         pready;
        logic         pslverr;
        logic [31:0]  prdata;
    } epb_state_type;
endpackage

// file: verification/epb_sw_model.sv
// Purpose: model of the power switch drivers behind the bridge pins
// Assumes: active-high polarity; leg one is a/b, leg two is c/d
// Notes:   counts cycles where both switches of one leg conduct
`timescale 1ns/1ps
module epb_sw_model (
    input  wire logic                  pclk,
    input  wire epb_pkg::epb_pins_type bridge_pins,
    input  wire logic                  cap_drive,
    output logic                       capture_in,
    output logic [15:0]                shoot_cnt
);
    logic [3:0] on_sw;

    // a released pin leaves its driver off, as the driver pull-down does
    assign on_sw      = bridge_pins.lvl & bridge_pins.oe;
    assign capture_in = cap_drive;

    initial shoot_cnt = 16'h0000;

    // overlap inside one leg is shoot-through; only a count, no judgement
    always @(posedge pclk) begin
        if ((on_sw[0] && on_sw[1]) || (on_sw[2] && on_sw[3])) begin
            shoot_cnt <= shoot_cnt + 16'h0001;
        end
    end
endmodule

// file: verification/enhanced_pwm_bridge_control_test.sv
// Purpose: self-checking bench for the pwm bridge control block
// Assumes: apb master acts on rising edges, outputs sampled on falling
// Notes:   period register kept at 3, so one pwm period is 16*prescale
`timescale 1ns/1ps
module enhanced_pwm_bridge_control_test;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [3:0] oe;
        logic [3:0] lvl;
        logic [3:0] msk;
    } epb_row_type;

    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [7:0]            paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  capture_in;
    logic                  cap_drive;
    logic                  irq;
    logic [15:0]           shoot_cnt;
    epb_pkg::epb_pins_type bridge_pins;
    logic [31:0]           rdat;
    logic                  rerr;
    int                    num_errors;
    int                    checked;
    epb_row_type           rows [16];

    epb_bridge epb_bridge_i (
        .pclk        (pclk),
        .presetn     (presetn),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .capture_in  (capture_in),
        .bridge_pins (bridge_pins),
        .irq         (irq)
    );

    epb_sw_model epb_sw_model_i (
        .pclk        (pclk),
        .bridge_pins (bridge_pins),
        .cap_drive   (cap_drive),
        .capture_in  (capture_in),
        .shoot_cnt   (shoot_cnt)
    );

    initial pclk = 1'b0;
    always #4 pclk = ~pclk;

    task automatic wrap_up;
        if (num_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // request held until the rising edge that sees pready high
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            if (n > 16) begin
                num_errors++;
                $display("MISMATCH %0t bus timeout", $time);
                wrap_up();
            end
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic count_hi(input int idx, input int n, output int c);
        c = 0;
        repeat (n) begin
            @(negedge pclk);
            if (bridge_pins.lvl[idx] === 1'b1) c++;
        end
    endtask

    initial begin
        int i, c, w, z, n;
        logic [15:0] s0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        cap_drive = 1'b0;
        num_errors = 0;
        checked = 0;
        rows = '{
            '{8'h00, 4'h0, 4'h0, 4'h0},
            '{8'h02, 4'h1, 4'h0, 4'h0},
            '{8'h04, 4'h0, 4'h0, 4'h0},
            '{8'h05, 4'h0, 4'h0, 4'h0},
            '{8'h08, 4'h1, 4'h0, 4'h1},
            '{8'h09, 4'h1, 4'h1, 4'h1},
            '{8'h0a, 4'h0, 4'h0, 4'h0},
            '{8'h0b, 4'h0, 4'h0, 4'h0},
            '{8'h0c, 4'h1, 4'h0, 4'h1},
            '{8'h4c, 4'hf, 4'h1, 4'hf},
            '{8'h4d, 4'hf, 4'hb, 4'hf},
            '{8'h4e, 4'hf, 4'h4, 4'hf},
            '{8'h4f, 4'hf, 4'he, 4'hf},
            '{8'h8c, 4'h3, 4'h0, 4'h1},
            '{8'hcc, 4'hf, 4'h4, 4'hf},
            '{8'hc8, 4'h1, 4'h0, 4'h1}
        };
        cyc(20);
        presetn <= 1'b1;
        wr(epb_pkg::OFF_PERIOD, 32'h3);
        wr(epb_pkg::OFF_CMP, 32'hffff);
        for (i = 0; i < 16; i++) begin
            wr(epb_pkg::OFF_CTRL, 32'h0);
            wr(epb_pkg::OFF_CTRL, 32'(rows[i].ctrl));
            cyc(40);
            rd(epb_pkg::OFF_CTRL);
            chk(rdat, 32'(rows[i].ctrl));
            @(negedge pclk);
            chk(32'(bridge_pins.oe), 32'(rows[i].oe));
            chk(32'(bridge_pins.lvl & rows[i].msk),
                32'(rows[i].lvl));
        end
        // reset in mid-run, then every register and one unmapped word
        wr(epb_pkg::OFF_CTRL, 32'h4c);
        cyc(4);
        presetn <= 1'b0;
        cyc(3);
        @(negedge pclk);
        chk(32'({bridge_pins, irq}), 32'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 9; i++) begin
            rd(8'(4 * i));
            chk(rdat, (8'(4 * i) == epb_pkg::OFF_PERIOD) ?
                32'(epb_pkg::PERIOD_RST) : 32'h0);
            chk(32'(rerr), 32'(i == 8));
        end
        wr(epb_pkg::OFF_PERIOD, 32'h3);
        wr(epb_pkg::OFF_CMP, 32'h40);
        wr(epb_pkg::OFF_MASK, 32'h1);
        for (i = 0; i < 3; i++) begin
            wr(epb_pkg::OFF_CTRL, 32'h0);
            rd(epb_pkg::OFF_STAT);
            wr(epb_pkg::OFF_CTRL, 32'(8 + i));
            n = 0;
            @(negedge pclk);
            while (irq !== 1'b1 && n < 200) begin
                n++;
                @(negedge pclk);
            end
            chk(32'(irq), 32'h1);
            chk(32'({bridge_pins.oe[0], bridge_pins.lvl[0] &
                bridge_pins.oe[0]}), 32'({i != 2, i == 0}));
            rd(epb_pkg::OFF_STAT);
            chk(32'(rdat[0]), 32'h1);
            rd(epb_pkg::OFF_STAT);
            chk(32'(rdat[0]), 32'h0);
            cyc(2);
            @(negedge pclk);
            chk(32'(irq), 32'h0);
        end
        // masked special event: timer keeps wrapping at the match value
        wr(epb_pkg::OFF_CTRL, 32'h0);
        wr(epb_pkg::OFF_MASK, 32'h0);
        wr(epb_pkg::OFF_CTRL, 32'h0b);
        cyc(150);
        @(negedge pclk);
        chk(32'(irq), 32'h0);
        rd(epb_pkg::OFF_FIRST_TIMER_COUNT);
        chk(32'(rdat[15:0] <= 16'h0040), 32'h1);
        rd(epb_pkg::OFF_STAT);
        chk(32'(rdat[0]), 32'h1);
        wr(epb_pkg::OFF_CTRL, 32'h0);
        wr(epb_pkg::OFF_CTRL, 32'h05);
        rd(epb_pkg::OFF_STAT);
        cap_drive <= 1'b1;
        cyc(4);
        rd(epb_pkg::OFF_STAT);
        chk(32'(rdat[0]), 32'h1);
        // duty 6 of 16 steps, at each prescale
        wr(epb_pkg::OFF_CTRL, 32'h0);
        wr(epb_pkg::OFF_DUTY, 32'h1);
        wr(epb_pkg::OFF_CTRL, 32'h2c);
        for (i = 0; i < 3; i++) begin
            wr(epb_pkg::OFF_PRESC, 32'(i));
            cyc(32 << (2 * i));
            count_hi(0, 160 << (2 * i), c);
            chk(32'(c), 32'(60 << (2 * i)));
        end
        wr(epb_pkg::OFF_PRESC, 32'h0);
        wr(epb_pkg::OFF_CTRL, 32'hac);
        cyc(32);
        z = 0;
        w = 0;
        repeat (160) begin
            @(negedge pclk);
            if (bridge_pins.lvl[1:0] === 2'b00) z++;
            if (bridge_pins.lvl[1:0] === 2'b11) w++;
        end
        chk(32'(z), 32'd40);
        chk(32'(w), 32'd0);
        // reversal at duty 15, then back at a lowered duty
        s0 = shoot_cnt;
        for (i = 0; i < 2; i++) begin
            wr(epb_pkg::OFF_PRESC, 32'(i));
            wr(epb_pkg::OFF_DUTY, i ? 32'h2 : 32'h3);
            wr(epb_pkg::OFF_CTRL, i ? 32'hcc : 32'h7c);
            cyc(200);
            // change direction early in a period so the whole window shows
            n = 0;
            while (bridge_pins.lvl[i ? 1 : 3] !== 1'b0 && n < 400) begin
                @(negedge pclk);
                n++;
            end
            while (bridge_pins.lvl[i ? 1 : 3] !== 1'b1 && n < 400) begin
                @(negedge pclk);
                n++;
            end
            wr(epb_pkg::OFF_CTRL, i ? 32'h4c : 32'hfc);
            w = 0;
            z = 0;
            n = 0;
            while (!(w > 0 && bridge_pins.lvl[i ? 3 : 1] === 1'b1)
                   && n < 400) begin
                @(negedge pclk);
                n++;
                if (bridge_pins.lvl === (i ? 4'h1 : 4'h4)) w++;
                if (bridge_pins.lvl === 4'h0) z++;
            end
            chk(32'(w), 32'(4 << (2 * i)));
            chk(32'(z), 32'h0);
        end
        chk(32'(shoot_cnt), 32'(s0));
        wrap_up();
    end
endmodule
